// *** design/temperature_result_readout_defines.vh ***
// constants for the temperature result readout block
`ifndef TEMPERATURE_RESULT_READOUT_DEFINES_VH
`define TEMPERATURE_RESULT_READOUT_DEFINES_VH

// register selector value of the result register and reset values
`define TEMP_RESULT_OFFSET 2'h0
`define TEMP_RESULT_RESET 16'h0000
`define POINTER_RESET 2'h0

// field layout of the result word
`define TEMP_SIGN_BIT 15
`define TEMP_VALUE_LSB 4

// fixed upper nibble of the bus address
`define DEV_ADDR_FIXED 4'h9

// resolution_select codes
`define RES_9BIT 2'h0
`define RES_10BIT 2'h1
`define RES_11BIT 2'h2
`define RES_12BIT 2'h3

// zero-fill masks per resolution
`define MASK_9BIT 16'hFF80
`define MASK_10BIT 16'hFFC0
`define MASK_11BIT 16'hFFE0
`define MASK_12BIT 16'hFFF0

// conversion_duration at 9 bits, in ms, and clock rate in kHz
`define CONV_9BIT_MS 22'd25
`define CLK_KHZ 22'd10000
`define CONV_9BIT_CYCLES (`CONV_9BIT_MS * `CLK_KHZ)

// bus state codes
`define ST_IDLE 3'h0
`define ST_ADDR 3'h1
`define ST_ADDR_ACK 3'h2
`define ST_WR_BYTE 3'h3
`define ST_WR_ACK 3'h4
`define ST_RD_BYTE 3'h5
`define ST_RD_ACK 3'h6

`endif

// *** design/temperature_result_readout.v ***
// two-wire slave that reads out the temperature result register
//
// Summary of operation
// - 16-bit result register, read-only over bus
// - two's complement, unused low bits zero
// - bit 15 holds sign
// - value left-aligned; zero-fill by resolution
// - 12-bit: bit 4 weighs 1/16 degree
// - reads never disturb background conversions
// - new result loads only when not read
// - address 1001 plus straps plus one acknowledged
// - upper byte first, master ack gets lower
// - nack after lower byte releases data line
// - ack after lower byte restarts upper byte
// - nack after upper byte skips lower byte
// - result reads zero after reset
// - writes to result register get nack
// - resolution code picks bits, doubling conversion time
// - pointer resets to result register
`timescale 1ns/1ns
`default_nettype none
`include "temperature_result_readout_defines.vh"

module temperature_result_readout #(
  parameter [21:0] CONV_9BIT_CYCLES = `CONV_9BIT_CYCLES
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_sys_rst,
  // two-wire bus pins
  input wire i_scl,
  input wire i_sda_in,
  output wire o_sda_out,
  output wire o_sda_oe,
  // address strap pins
  input wire [2:0] i_address_strap_pins,
  // converter side, same clock
  input wire [11:0] i_adc_sample,
  input wire [1:0] i_resolution_select,
  // state seen by the rest of the device
  output wire [15:0] o_temperature_result,
  output wire [1:0] o_pointer_value,
  output wire o_conversion_done
);

  // zero-fill mask for a resolution code
  function [15:0] res_mask;
    input [1:0] res;
    begin
      case (res)
        `RES_9BIT: res_mask = `MASK_9BIT;
        `RES_10BIT: res_mask = `MASK_10BIT;
        `RES_11BIT: res_mask = `MASK_11BIT;
        default: res_mask = `MASK_12BIT;
      endcase
    end
  endfunction

  // conversion length in cycles, doubling per resolution step
  function [21:0] conv_limit;
    input [1:0] res;
    begin
      conv_limit = CONV_9BIT_CYCLES << res;
    end
  endfunction

  // pin synchronisers
  reg scl_meta_r;
  reg scl_sync_r;
  reg scl_prev_r;
  reg sda_meta_r;
  reg sda_sync_r;
  reg sda_prev_r;
  reg [2:0] strap_meta_r;
  reg [2:0] strap_sync_r;

  // bus engine state
  reg [2:0] state_r;
  reg [7:0] shift_r;
  reg [2:0] bit_cnt_r;
  reg rw_r;
  reg ack_on_r;
  reg ack_ok_r;
  reg wr_first_r;
  reg byte_lo_r;
  reg sda_oe_r;
  reg sda_out_r;
  reg [1:0] pointer_r;

  // conversion and result state
  reg [21:0] conv_cnt_r;
  reg [15:0] result_r;
  reg [15:0] pending_r;
  reg pending_vld_r;
  reg conv_done_r;

  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire reading;
  wire [7:0] addr_byte;
  wire [15:0] rd_word;
  wire [15:0] fresh_value;
  wire conv_end;

  assign scl_rise = scl_sync_r & ~scl_prev_r;
  assign scl_fall = ~scl_sync_r & scl_prev_r;
  assign start_cond = scl_sync_r & scl_prev_r & sda_prev_r & ~sda_sync_r;
  assign stop_cond = scl_sync_r & scl_prev_r & ~sda_prev_r & sda_sync_r;
  assign addr_byte = {shift_r[6:0], sda_sync_r};
  // other selector values belong to registers outside this block
  assign rd_word = (pointer_r == `TEMP_RESULT_OFFSET) ? result_r : 16'h0000;
  // holding the word while it goes out keeps the two bytes consistent
  assign reading = rw_r & ((state_r == `ST_ADDR_ACK) | (state_r == `ST_RD_BYTE) | (state_r == `ST_RD_ACK));
  assign fresh_value = {i_adc_sample, 4'h0} & res_mask(i_resolution_select);
  assign conv_end = (conv_cnt_r >= conv_limit(i_resolution_select) - 22'd1);

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      scl_meta_r <= 1'b1;
      scl_sync_r <= 1'b1;
      scl_prev_r <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
      sda_prev_r <= 1'b1;
      strap_meta_r <= 3'h0;
      strap_sync_r <= 3'h0;
    end else begin
      scl_meta_r <= i_scl;
      scl_sync_r <= scl_meta_r;
      scl_prev_r <= scl_sync_r;
      sda_meta_r <= i_sda_in;
      sda_sync_r <= sda_meta_r;
      sda_prev_r <= sda_sync_r;
      strap_meta_r <= i_address_strap_pins;
      strap_sync_r <= strap_meta_r;
    end
  end

  // background conversions run regardless of bus activity
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      conv_cnt_r <= 22'd0;
      result_r <= `TEMP_RESULT_RESET;
      pending_r <= `TEMP_RESULT_RESET;
      pending_vld_r <= 1'b0;
      conv_done_r <= 1'b0;
    end else begin
      conv_done_r <= conv_end;
      if (conv_end) begin
        conv_cnt_r <= 22'd0;
      end else begin
        conv_cnt_r <= conv_cnt_r + 22'd1;
      end
      if (conv_end && !reading) begin
        result_r <= fresh_value;
        pending_vld_r <= 1'b0;
      end else if (conv_end) begin
        pending_r <= fresh_value;
        pending_vld_r <= 1'b1;
      end else if (pending_vld_r && !reading) begin
        result_r <= pending_r & res_mask(i_resolution_select);
        pending_vld_r <= 1'b0;
      end
    end
  end

  // bus engine: sample on scl rise, drive on scl fall
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state_r <= `ST_IDLE;
      shift_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      rw_r <= 1'b0;
      ack_on_r <= 1'b0;
      ack_ok_r <= 1'b0;
      wr_first_r <= 1'b0;
      byte_lo_r <= 1'b0;
      sda_oe_r <= 1'b0;
      sda_out_r <= 1'b0;
      pointer_r <= `POINTER_RESET;
    end else begin
      sda_out_r <= 1'b0;
      if (start_cond) begin
        state_r <= `ST_ADDR;
        bit_cnt_r <= 3'h0;
        rw_r <= 1'b0;
        ack_on_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end else if (stop_cond) begin
        state_r <= `ST_IDLE;
        rw_r <= 1'b0;
        ack_on_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end else begin
        case (state_r)
          `ST_ADDR: begin
            if (scl_rise) begin
              shift_r <= addr_byte;
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == 3'h7) begin
                if (addr_byte[7:1] == {`DEV_ADDR_FIXED, strap_sync_r}) begin
                  state_r <= `ST_ADDR_ACK;
                  rw_r <= addr_byte[0];
                end else begin
                  state_r <= `ST_IDLE;
                end
              end
            end
          end
          `ST_ADDR_ACK: begin
            if (scl_fall && !ack_on_r) begin
              sda_oe_r <= 1'b1;
              ack_on_r <= 1'b1;
            end else if (scl_fall) begin
              ack_on_r <= 1'b0;
              bit_cnt_r <= 3'h0;
              if (rw_r) begin
                state_r <= `ST_RD_BYTE;
                byte_lo_r <= 1'b0;
                shift_r <= rd_word[15:8];
                sda_oe_r <= ~rd_word[15];
              end else begin
                state_r <= `ST_WR_BYTE;
                wr_first_r <= 1'b1;
                sda_oe_r <= 1'b0;
              end
            end
          end
          `ST_WR_BYTE: begin
            if (scl_rise) begin
              shift_r <= addr_byte;
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == 3'h7) begin
                state_r <= `ST_WR_ACK;
                wr_first_r <= 1'b0;
                if (wr_first_r) begin
                  ack_ok_r <= 1'b1;
                  // out-of-range selector values are acked but ignored
                  if (addr_byte[7:2] == 6'h00) begin
                    pointer_r <= addr_byte[1:0];
                  end
                end else begin
                  ack_ok_r <= (pointer_r != `TEMP_RESULT_OFFSET);
                end
              end
            end
          end
          `ST_WR_ACK: begin
            if (scl_fall && !ack_on_r) begin
              if (ack_ok_r) begin
                sda_oe_r <= 1'b1;
                ack_on_r <= 1'b1;
              end else begin
                state_r <= `ST_IDLE;
                sda_oe_r <= 1'b0;
              end
            end else if (scl_fall) begin
              ack_on_r <= 1'b0;
              sda_oe_r <= 1'b0;
              bit_cnt_r <= 3'h0;
              state_r <= `ST_WR_BYTE;
            end
          end
          `ST_RD_BYTE: begin
            if (scl_fall) begin
              if (bit_cnt_r == 3'h7) begin
                state_r <= `ST_RD_ACK;
                sda_oe_r <= 1'b0;
              end else begin
                shift_r <= {shift_r[6:0], 1'b0};
                sda_oe_r <= ~shift_r[6];
                bit_cnt_r <= bit_cnt_r + 3'h1;
              end
            end
          end
          `ST_RD_ACK: begin
            if (scl_rise && sda_sync_r) begin
              state_r <= `ST_IDLE;
              rw_r <= 1'b0;
            end else if (scl_fall) begin
              state_r <= `ST_RD_BYTE;
              bit_cnt_r <= 3'h0;
              byte_lo_r <= ~byte_lo_r;
              if (byte_lo_r) begin
                shift_r <= rd_word[15:8];
                sda_oe_r <= ~rd_word[15];
              end else begin
                shift_r <= rd_word[7:0];
                sda_oe_r <= ~rd_word[7];
              end
            end
          end
          default: begin
            state_r <= `ST_IDLE;
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  assign o_sda_out = sda_out_r;
  assign o_sda_oe = sda_oe_r;
  assign o_temperature_result = result_r;
  assign o_pointer_value = pointer_r;
  assign o_conversion_done = conv_done_r;

endmodule // temperature_result_readout

`default_nettype wire

// *** tb/readout_props.sv ***
// assertion checker for the temperature result readout ports
`timescale 1ns/1ns
`default_nettype none
module readout_props #(
  parameter [21:0] CONV_9BIT_CYCLES = 22'd40
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // bus pins and straps
  input wire logic i_scl,
  input wire logic i_sda_in,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic [2:0] i_address_strap_pins,
  // converter side and state
  input wire logic [11:0] i_adc_sample,
  input wire logic [1:0] i_resolution_select,
  input wire logic [15:0] o_temperature_result,
  input wire logic [1:0] o_pointer_value,
  input wire logic o_conversion_done
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  a_out_low: assert property (!o_sda_out)
    else $error("data pin driven high");
  a_reset_clear: assert property (disable iff (1'b0) i_sys_rst |=> o_temperature_result == 16'h0000
    && o_pointer_value == 2'h0 && !o_sda_oe && !o_conversion_done) else $error("reset state wrong");
  a_low_zero: assert property (o_temperature_result[3:0] == 4'h0)
    else $error("low nibble not zero");
  a_zero_fill: assert property ($changed(o_temperature_result) |->
    (o_temperature_result & (16'h007F >> $past(i_resolution_select))) == 16'h0000) else $error("zero fill wrong");
  a_done_gap: assert property (o_conversion_done |=> !o_conversion_done [*8])
    else $error("conversions too close");
  a_done_start: assert property ($fell(i_sys_rst) |-> !o_conversion_done [*8])
    else $error("conversion ended too early");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !$past(i_scl, 2))
    else $error("data changed with clock high");
  a_quiet_start: assert property ($fell(i_sys_rst) |-> !o_sda_oe [*4])
    else $error("data pulled after reset");
  c_done: cover property (o_conversion_done);
  c_ack: cover property ($rose(o_sda_oe));
  c_negative: cover property ($changed(o_temperature_result) && o_temperature_result[15]);
endmodule // readout_props
bind temperature_result_readout readout_props #(.CONV_9BIT_CYCLES(CONV_9BIT_CYCLES)) u_props (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_scl(i_scl), .i_sda_in(i_sda_in), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .i_address_strap_pins(i_address_strap_pins), .i_adc_sample(i_adc_sample),
  .i_resolution_select(i_resolution_select), .o_temperature_result(o_temperature_result),
  .o_pointer_value(o_pointer_value), .o_conversion_done(o_conversion_done));
`default_nettype wire

// *** tb/bus_master_model.sv ***
// two-wire bus master that reads the sensor
`timescale 1ns/1ns
`default_nettype none
module bus_master_model (
  // clock
  input wire logic i_clk_sys,
  // pins
  input wire logic i_sda_oe,
  output logic o_scl,
  output logic o_sda
);
  logic drv_sda = 1'b1;
  int slow = 0;
  // pull-up on the wire: the device can only pull low
  assign o_sda = drv_sda & ~i_sda_oe;
  initial o_scl = 1'b1;
  task automatic q();
    repeat (2 + slow) @(posedge i_clk_sys);
  endtask
  task automatic start();
    q();
    drv_sda <= 1'b0;
    q();
    o_scl <= 1'b0;
  endtask
  task automatic bit_x(input logic b, output logic r);
    q();
    drv_sda <= b;
    q();
    o_scl <= 1'b1;
    q();
    r = o_sda;
    q();
    o_scl <= 1'b0;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(~ack, r);
  endtask
  task automatic stop();
    q();
    drv_sda <= 1'b0;
    q();
    o_scl <= 1'b1;
    q();
    drv_sda <= 1'b1;
    q();
  endtask
endmodule // bus_master_model
`default_nettype wire

// *** tb/temperature_result_readout_test.sv ***
// self-checking bench for the temperature result readout
`timescale 1ns/1ns
`default_nettype none
module temperature_result_readout_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] straps = 3'h0;
  logic [11:0] adc = 12'h000;
  logic [1:0] res = 2'h0;
  logic scl, sda, oe, done;
  logic [15:0] result, model;
  logic [1:0] ptr;
  logic [31:0] seed = 32'hB7BB;
  logic a;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  bus_master_model u_master (.i_clk_sys(clk), .i_sda_oe(oe), .o_scl(scl), .o_sda(sda));
  temperature_result_readout #(.CONV_9BIT_CYCLES(22'd40)) u_dut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda_in(sda), .o_sda_out(), .o_sda_oe(oe),
    .i_address_strap_pins(straps), .i_adc_sample(adc), .i_resolution_select(res),
    .o_temperature_result(result), .o_pointer_value(ptr), .o_conversion_done(done));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // conversion periods stay short because the period parameter is shrunk
  task automatic wait_conv();
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (done !== 1'b1 && k < 2000);
    if (k >= 2000) errors++;
  endtask
  task automatic settle(input logic [1:0] r, input logic [11:0] s);
    @(posedge clk);
    res <= r;
    adc <= s;
    wait_conv();
    wait_conv();
    model = {s, 4'h0} & ~(16'h007F >> r);
    chk("result", result, model);
  endtask
  task automatic rd(input int mode, input logic [11:0] nxt);
    logic [7:0] b;
    u_master.start();
    u_master.send({4'h9, straps, 1'b1}, a);
    chk("read ack", a, 1'b1);
    // earlier changes would reload the register before the read began
    adc <= nxt;
    u_master.recv(mode != 0, b);
    chk("upper", b, model[15:8]);
    if (mode != 0) begin
      u_master.recv(mode == 2, b);
      chk("lower", b, model[7:0]);
    end
    if (mode == 2) begin
      u_master.recv(1'b0, b);
      chk("again", b, model[15:8]);
    end
    u_master.stop();
    @(negedge clk);
    chk("released", oe, 1'b0);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    seed = xs(seed);
    @(posedge clk);
    straps <= seed[2:0];
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("reset result", result, 16'h0000);
    chk("reset pointer", ptr, 2'h0);
    settle(2'h3, 12'h001);
    settle(2'h3, 12'hFFF);
    for (int r = 0; r < 4; r++) begin
      seed = xs(seed);
      settle(r[1:0], seed[11:0]);
      // conversions ending mid-read must not reach the bytes
      u_master.slow = r;
      rd(r % 3, ~seed[11:0]);
      wait_conv();
      model = {~seed[11:0], 4'h0} & ~(16'h007F >> r);
      chk("after read", result, model);
    end
    u_master.start();
    u_master.send({4'h9, straps, 1'b0}, a);
    u_master.send(8'h03, a);
    chk("other pointer ack", a, 1'b1);
    u_master.send(seed[7:0], a);
    chk("other data ack", a, 1'b1);
    u_master.stop();
    @(negedge clk);
    chk("pointer moved", ptr, 2'h3);
    u_master.start();
    u_master.send({4'h9, straps, 1'b0}, a);
    chk("write ack", a, 1'b1);
    u_master.send(8'h00, a);
    chk("pointer ack", a, 1'b1);
    u_master.send(seed[7:0], a);
    chk("data nack", a, 1'b0);
    u_master.stop();
    @(negedge clk);
    chk("pointer back", ptr, 2'h0);
    u_master.start();
    u_master.send({4'h9, ~straps, 1'b1}, a);
    chk("foreign ack", a, 1'b0);
    u_master.stop();
    @(negedge clk);
    chk("kept", result, model);
    test_done();
  end
endmodule // temperature_result_readout_test
`default_nettype wire
